// ### hw/rtc_params.svh
// Register offsets, field layouts, reset values and timing figures
// Assumes: included by bare name from the countdown and calendar modules, checker and testbench
`ifndef RTC_PARAMS_SVH
`define RTC_PARAMS_SVH

// ==========================================================
// Register offsets (byte addresses, 8-bit address)
`define OFS_CTRL      8'h00
`define OFS_CAL       8'h04
`define OFS_PER_SEL   8'h08
`define OFS_ALM_MASK  8'h0C
`define OFS_CD        8'h10
`define OFS_STATUS    8'h14
`define OFS_MASK      8'h18
`define OFS_WAKE      8'h1C
// Time fields at 0x20 + 4*index, alarm fields at 0x40 + 4*index
`define BANK_TIME     3'h1
`define BANK_ALARM    3'h2

// ==========================================================
// Field positions
`define CTRL_RUN_BIT  0
`define CAL_DIR_BIT   17
`define ST_CD_BIT     0
`define ST_PER_BIT    1
`define ST_ALM_BIT    2

// ==========================================================
// Calendar limits and reset values
`define SEC_MAX       12'h03B
`define MIN_MAX       12'h03B
`define HOUR_MAX      12'h017
`define MON_MAX       12'h00C
`define DOW_MAX       12'h006
`define DOY_MAX       12'h16E
`define FLD_ZERO      12'h000
`define FLD_ONE       12'h001
`define CTRL_RST      1'h1
`define CAL_RST       18'h00000
`define CD_RST        16'h0000
`define PER_SEL_RST   8'h00
`define ALM_MASK_RST  8'hFF
`define EN_RST        3'h0
`define STATUS_RST    3'h0

// ==========================================================
// Timing figures
`define CLK_FREQ_HZ   50000000
`define SEC_TICK_HZ   1
`define MS_TICK_HZ    1000

`endif

// ### hw/rtc_pkg.sv
// Types shared by the timekeeping modules
// Assumes: constants come from rtc_params.svh
package rtc_pkg;

    // ==========================================================
    // Calendar field indices, in carry order
    typedef enum {
        FLD_SEC, FLD_MIN, FLD_HOUR, FLD_DOM,
        FLD_MON, FLD_YEAR, FLD_DOW, FLD_DOY
    } field_e;

    typedef logic [11:0] field_t;

endpackage

// ### hw/rtc_tick_div.sv
// Divider that turns clk into a one-cycle enable pulse
// Assumes: DIV is at least 2; en low holds the phase at zero
`timescale 1ns/1ps
module rtc_tick_div #(
    parameter int unsigned DIV = 2
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Control and pulse
    input  wire logic en,
    output logic      tick
);
    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cnt_reg;
    wire          at_last = (cnt_reg == LAST);

    // ==========================================================
    // Phase counter, restarted whenever disabled
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
            tick    <= 1'b0;
        end else begin
            cnt_reg <= (!en || at_last) ? '0 : cnt_reg + 1'b1;
            tick    <= en && at_last;
        end
    end
endmodule

// ### hw/rtc_countdown.sv
// Sixteen-bit countdown alarm timer on a millisecond enable
// Assumes: load is a one-cycle pulse from the register port
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_countdown (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Time base and reload
    input  wire logic        ms_tick,
    input  wire logic        load,
    input  wire logic [15:0] preset,
    // State
    output logic      [15:0] count,
    output logic             zero
);
    logic run_reg;
    wire  last = (count == 16'h0001);

    // ==========================================================
    // Reload wins over a tick in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count   <= `CD_RST;
            run_reg <= 1'b0;
            zero    <= 1'b0;
        end else if (load) begin
            count   <= preset;                // [RULE6]
            run_reg <= (preset != 16'h0000);
            zero    <= 1'b0;
        end else if (ms_tick && run_reg) begin
            count   <= count - 16'h0001;      // [RULE7]
            run_reg <= !last;                 // Holds at zero [RULE11]
            zero    <= last;                  // [RULE8]
        end else begin
            zero    <= 1'b0;
        end
    end
endmodule

// ### hw/rtc_calendar.sv
// Calendar clock with calibration, periodic and date alarms,
// plus the countdown alarm timer, behind a simple register port
// Assumes: single 50 MHz clock stands in for the low-speed
// oscillator; bus master obeys one-cycle strobes
`timescale 1ns/1ps
`include "rtc_params.svh"

// Notes on behaviour
// RULE1: Divide clock down to one-second advance tick
// RULE2: Eight calendar counters carrying into each other
// RULE3: Calibration periodically adds or drops one second
// RULE4: Periodic interrupt on increment of selected field
// RULE5: Alarm interrupt when programmed date/time matches
// RULE6: Countdown is 16-bit, loaded from software preset
// RULE7: Countdown decrements on each millisecond tick
// RULE8: Countdown reaching zero sets readable status flag
// RULE9: Countdown interrupt only when its enable set
// RULE10: Calendar and countdown events drive wake output
// RULE11: Flag sticks until cleared; counter holds zero
module rtc_calendar
    import rtc_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = `CLK_FREQ_HZ / `SEC_TICK_HZ,
    parameter int unsigned MS_CYCLES  = `CLK_FREQ_HZ / `MS_TICK_HZ
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [31:0] rdata,
    // Events
    output logic             irq,
    output logic             wake
);

    // ==========================================================
    // State
    field_t      time_reg  [8];
    field_t      alarm_reg [8];
    field_t      time_next [8];
    logic        run_reg;
    logic [17:0] cal_reg;
    logic [16:0] cal_cnt_reg;
    logic        extra_reg;
    logic        adv_d_reg;
    logic [7:0]  per_sel_reg;
    logic [7:0]  alm_mask_reg;
    logic [2:0]  status_reg;
    logic [2:0]  status_next;
    logic [2:0]  mask_reg;
    logic [2:0]  wake_en_reg;
    logic [15:0] cd_preset_reg;
    logic [31:0] rdata_next;

    // ==========================================================
    // Address decode
    // Misaligned addresses match nothing, so writes there are dropped
    wire [2:0] bank     = addr[7:5];
    wire [2:0] fidx     = addr[4:2];
    wire       is_ctl   = (bank == 3'h0) && (addr[1:0] == 2'b00);
    wire       is_time  = (bank == `BANK_TIME) && (addr[1:0] == 2'b00);
    wire       is_alarm = (bank == `BANK_ALARM) && (addr[1:0] == 2'b00);
    wire       wr_ctrl  = wr && is_ctl && (addr == `OFS_CTRL);
    wire       wr_cal   = wr && is_ctl && (addr == `OFS_CAL);
    wire       wr_per   = wr && is_ctl && (addr == `OFS_PER_SEL);
    wire       wr_amsk  = wr && is_ctl && (addr == `OFS_ALM_MASK);
    wire       wr_cd    = wr && is_ctl && (addr == `OFS_CD);
    wire       wr_stat  = wr && is_ctl && (addr == `OFS_STATUS);
    wire       wr_mask  = wr && is_ctl && (addr == `OFS_MASK);
    wire       wr_wake  = wr && is_ctl && (addr == `OFS_WAKE);
    wire       wr_time  = wr && is_time;
    wire       wr_alarm = wr && is_alarm;

    // ==========================================================
    // Time bases
    // Stopping the calendar clears the divider phase, so a restart
    // waits a full second before the first advance
    logic        sec_tick;
    logic        ms_tick;
    logic [15:0] cd_count;
    logic        cd_zero;

    // One-second tick pauses while the clock is stopped [RULE1]
    rtc_tick_div #(.DIV(SEC_CYCLES)) u_sec_div (
        .clk  (clk),
        .rst  (rst),
        .en   (run_reg),
        .tick (sec_tick)
    );

    // Millisecond time base runs free for the countdown [RULE7]
    rtc_tick_div #(.DIV(MS_CYCLES)) u_ms_div (
        .clk  (clk),
        .rst  (rst),
        .en   (1'b1),
        .tick (ms_tick)
    );

    // Countdown timer, reloaded by a write of its preset [RULE6]
    rtc_countdown u_cd (
        .clk     (clk),
        .rst     (rst),
        .ms_tick (ms_tick),
        .load    (wr_cd),
        .preset  (wdata[15:0]),
        .count   (cd_count),
        .zero    (cd_zero)
    );

    // ==========================================================
    // Calibration: a hit every period seconds; direction picks
    // an extra advance or a dropped one
    wire [16:0] cal_period = cal_reg[16:0];
    wire        cal_remove = cal_reg[`CAL_DIR_BIT];
    wire        cal_hit    = sec_tick && (cal_period != 17'h00000)
                             && (cal_cnt_reg == cal_period - 17'h00001);
    wire        cal_drop   = cal_hit && cal_remove;            // [RULE3]
    wire        sec_adv    = (sec_tick && !cal_drop) || extra_reg;

    // ==========================================================
    // Day limit for the current month, leap every fourth year
    // Century years get no correction; a known limitation
    function automatic field_t days_in(input field_t mon, input field_t yr);
        field_t d;
        unique case (mon[3:0])
            4'h2:                      d = (yr[1:0] == 2'b00) ? 12'h01D : 12'h01C;
            4'h4, 4'h6, 4'h9, 4'hB:    d = 12'h01E;
            default:                   d = 12'h01F;
        endcase
        return d;
    endfunction

    // Value a field returns to after wrapping, and its reset value
    function automatic field_t low_of(input int i);
        return (i == FLD_DOM || i == FLD_MON || i == FLD_DOY) ? `FLD_ONE : `FLD_ZERO;
    endfunction

    // ==========================================================
    // Carry chain between fields [RULE2]
    // Weekday and day of year follow the day-of-month increment
    wire field_t day_max = days_in(time_reg[FLD_MON], time_reg[FLD_YEAR]);
    wire field_t doy_max = (time_reg[FLD_YEAR][1:0] == 2'b00) ? `DOY_MAX
                                                               : `DOY_MAX - `FLD_ONE;
    wire [7:0] top;
    wire [7:0] inc;
    assign top[FLD_SEC]  = (time_reg[FLD_SEC]  == `SEC_MAX);
    assign top[FLD_MIN]  = (time_reg[FLD_MIN]  == `MIN_MAX);
    assign top[FLD_HOUR] = (time_reg[FLD_HOUR] == `HOUR_MAX);
    assign top[FLD_DOM]  = (time_reg[FLD_DOM]  >= day_max);
    assign top[FLD_MON]  = (time_reg[FLD_MON]  >= `MON_MAX);
    assign top[FLD_YEAR] = (time_reg[FLD_YEAR] == 12'hFFF);
    assign top[FLD_DOW]  = (time_reg[FLD_DOW]  >= `DOW_MAX);
    assign top[FLD_DOY]  = inc[FLD_YEAR] || (time_reg[FLD_DOY] >= doy_max);
    assign inc[FLD_SEC]  = sec_adv;
    assign inc[FLD_MIN]  = inc[FLD_SEC]  && top[FLD_SEC];
    assign inc[FLD_HOUR] = inc[FLD_MIN]  && top[FLD_MIN];
    assign inc[FLD_DOM]  = inc[FLD_HOUR] && top[FLD_HOUR];
    assign inc[FLD_MON]  = inc[FLD_DOM]  && top[FLD_DOM];
    assign inc[FLD_YEAR] = inc[FLD_MON]  && top[FLD_MON];
    assign inc[FLD_DOW]  = inc[FLD_DOM];
    assign inc[FLD_DOY]  = inc[FLD_DOM];

    // Next field values; a software write beats the advance
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (wr_time && (fidx == 3'(i))) begin
                time_next[i] = wdata[11:0];
            end else if (inc[i]) begin
                time_next[i] = top[i] ? low_of(i) : time_reg[i] + `FLD_ONE;
            end else begin
                time_next[i] = time_reg[i];
            end
        end
    end

    // ==========================================================
    // Alarm compare over unmasked fields [RULE5]
    // Judged a cycle after the advance, once the new time has settled
    logic [7:0] alm_eq;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            alm_eq[i] = (time_reg[i] == alarm_reg[i]) || alm_mask_reg[i];
        end
    end
    wire alarm_hit = adv_d_reg && (&alm_eq);

    // Periodic event on any selected field increment [RULE4]
    wire per_hit = |(inc & per_sel_reg);

    // ==========================================================
    // Sticky status; a set in the clearing cycle survives
    wire [2:0] st_set = {alarm_hit, per_hit, cd_zero};
    wire [2:0] st_clr = wr_stat ? wdata[2:0] : 3'h0;
    assign status_next = (status_reg & ~st_clr) | st_set;      // [RULE11]

    // Countdown flag always lands; its line needs the mask bit [RULE9]
    // Both lines are levels; software clears the cause, not the line
    assign irq  = |(status_reg & mask_reg);
    assign wake = |(status_reg & wake_en_reg);                 // [RULE10]

    // ==========================================================
    // Calendar and alarm field registers
    // Day, month and day of year start at one, the rest at zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            time_reg[FLD_SEC]  <= `FLD_ZERO;
            time_reg[FLD_MIN]  <= `FLD_ZERO;
            time_reg[FLD_HOUR] <= `FLD_ZERO;
            time_reg[FLD_DOM]  <= `FLD_ONE;
            time_reg[FLD_MON]  <= `FLD_ONE;
            time_reg[FLD_YEAR] <= `FLD_ZERO;
            time_reg[FLD_DOW]  <= `FLD_ZERO;
            time_reg[FLD_DOY]  <= `FLD_ONE;
            for (int i = 0; i < 8; i++) begin
                alarm_reg[i] <= `FLD_ZERO;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                time_reg[i] <= time_next[i];
                if (wr_alarm && (fidx == 3'(i))) begin
                    alarm_reg[i] <= wdata[11:0];
                end
            end
        end
    end

    // Calibration counter restarts on a new setting [RULE3]
    // An added second lands one cycle after the hit, never on it
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cal_cnt_reg <= 17'h00000;
            extra_reg   <= 1'b0;
            adv_d_reg   <= 1'b0;
        end else begin
            if (wr_cal || cal_hit) begin
                cal_cnt_reg <= 17'h00000;
            end else if (sec_tick) begin
                cal_cnt_reg <= cal_cnt_reg + 17'h00001;
            end
            extra_reg <= cal_hit && !cal_remove;
            adv_d_reg <= sec_adv;
        end
    end

    // Control and status registers
    // Status always updates; the enables only gate the outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_reg       <= `CTRL_RST;
            cal_reg       <= `CAL_RST;
            per_sel_reg   <= `PER_SEL_RST;
            alm_mask_reg  <= `ALM_MASK_RST;
            mask_reg      <= `EN_RST;
            wake_en_reg   <= `EN_RST;
            cd_preset_reg <= `CD_RST;
            status_reg    <= `STATUS_RST;
        end else begin
            if (wr_ctrl) run_reg       <= wdata[`CTRL_RUN_BIT];
            if (wr_cal)  cal_reg       <= wdata[17:0];
            if (wr_per)  per_sel_reg   <= wdata[7:0];
            if (wr_amsk) alm_mask_reg  <= wdata[7:0];
            if (wr_mask) mask_reg      <= wdata[2:0];
            if (wr_wake) wake_en_reg   <= wdata[2:0];
            if (wr_cd)   cd_preset_reg <= wdata[15:0];
            status_reg <= status_next;
        end
    end

    // ==========================================================
    // Read selection; unmapped addresses read as zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (is_time) begin
            rdata_next = {20'h00000, time_reg[fidx]};
        end else if (is_alarm) begin
            rdata_next = {20'h00000, alarm_reg[fidx]};
        end else if (is_ctl) begin
            unique case (addr)
                `OFS_CTRL:     rdata_next = {31'h0, run_reg};
                `OFS_CAL:      rdata_next = {14'h0, cal_reg};
                `OFS_PER_SEL:  rdata_next = {24'h0, per_sel_reg};
                `OFS_ALM_MASK: rdata_next = {24'h0, alm_mask_reg};
                `OFS_CD:       rdata_next = {cd_preset_reg, cd_count};
                `OFS_STATUS:   rdata_next = {29'h0, status_reg};
                `OFS_MASK:     rdata_next = {29'h0, mask_reg};
                `OFS_WAKE:     rdata_next = {29'h0, wake_en_reg};
                default:       rdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    // Zero outside the answer cycle so a stale word never lingers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 32'h0000_0000;
        end else begin
            rdata <= rd ? rdata_next : 32'h0000_0000;
        end
    end

endmodule

// ### tb/rtc_calendar_chk.sv
// Checker for the calendar block's register port and event outputs
// Assumes: bound to rtc_calendar; sees its ports only
`timescale 1ns/1ps
`include "rtc_params.svh"
module rtc_calendar_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Register port
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    // Events
    input wire logic        irq,
    input wire logic        wake
);
    // ==========================================================
    // Single domain, so one clock and one reset serve every check
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Access steps on the countdown and the programmed registers
    sequence cd_read;
        rd && addr == `OFS_CD;
    endsequence
    sequence cd_write;
        wr && addr == `OFS_CD;
    endsequence
    sequence alm_wr_rd;
        (wr && addr == 8'h40) ##1 (rd && addr == 8'h40);
    endsequence
    sequence cal_wr_rd;
        (wr && addr == `OFS_CAL) ##1 (rd && addr == `OFS_CAL);
    endsequence

    // ==========================================================
    // Read data only after a read strobe
    AST_RDATA_IDLE: assert property (!rd |=> rdata == 32'h0)
        else $error("read data not zero outside a read");
    AST_IRQ_OFF: assert property (wr && addr == `OFS_MASK && wdata == 32'h0 |=> !irq)
        else $error("interrupt stays high with all enables cleared");
    AST_WAKE_OFF: assert property (wr && addr == `OFS_WAKE && wdata == 32'h0 |=> !wake)
        else $error("wake stays high with all enables cleared");
    AST_ALM_WR: assert property (alm_wr_rd |=> rdata == {20'h0, $past(wdata[11:0], 2)})
        else $error("alarm field does not read back");
    AST_CAL_WR: assert property (cal_wr_rd |=> rdata == {14'h0, $past(wdata[17:0], 2)})
        else $error("calibration setting does not read back");
    AST_CD_LOAD: assert property (cd_write ##1 cd_read |=> rdata[15:0] == $past(wdata[15:0], 2))
        else $error("countdown not loaded from preset");
    // Between two back-to-back reads the count drops by one at most
    AST_CD_STEP: assert property (cd_read ##1 cd_read |=>
        (rdata[15:0] == $past(rdata[15:0])) ||
        (rdata[15:0] == $past(rdata[15:0]) - 16'h0001))
        else $error("countdown moved by more than one step");
    AST_CD_HOLD: assert property (cd_read ##1 (rd && addr == `OFS_CD && rdata[15:0] == 16'h0) |=>
        rdata[15:0] == 16'h0)
        else $error("countdown left zero without a reload");
endmodule

// ### tb/testbench.sv
// Self-checking bench for the calendar and countdown alarm block
// Assumes: shortened tick periods; registers reached over the plain port
`timescale 1ns/1ps
`include "rtc_params.svh"
module testbench;
    import rtc_pkg::*;
    // ==========================================================
    // Shortened periods keep the run brief
    localparam int unsigned SEC_N = 20;
    localparam int unsigned MS_N  = 4;
    localparam logic [11:0] T_RST [0:7] = '{12'h0, 12'h0, 12'h0, 12'h1, 12'h1, 12'h0, 12'h0, 12'h1};
    localparam logic [11:0] T_IN  [0:7] = '{12'h3B, 12'h3B, 12'h17, 12'h1F, 12'hC, 12'h3, 12'h6, 12'h16D};
    localparam logic [11:0] T_OUT [0:7] = '{12'h0, 12'h0, 12'h0, 12'h1, 12'h1, 12'h4, 12'h0, 12'h1};
    logic        clk;
    logic        rst;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        irq;
    logic        wake;
    logic [31:0] d;
    int          n;
    int          n_errors = 0;
    int          compares = 0;

    rtc_calendar #(.SEC_CYCLES(SEC_N), .MS_CYCLES(MS_N)) dut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .irq(irq), .wake(wake)
    );

    // ==========================================================
    // Port tasks; each is entered just after a clock edge
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd_reg(a, d);
        chk(d, exp);
    endtask
    // Read until the masked value matches, bounded so a hang shows
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        output int k);
        k = 0;
        rd_reg(a, d);
        while ((d & m) !== e && k < 400) begin
            k++;
            rd_reg(a, d);
        end
        chk(d & m, e);
    endtask
    task automatic finish_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Free-running 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Tests need a few hundred cycles; this is a generous bound
    initial begin
        #(20000 * 20);
        n_errors++;
        finish_test();
    end

    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        #1;
        // Reset values, unmapped read, idle countdown
        for (int i = 0; i < 8; i++) rchk({`BANK_TIME, 3'(i), 2'h0}, {20'h0, T_RST[i]});
        rchk(`OFS_CTRL, 32'h1);
        rchk(`OFS_ALM_MASK, 32'hFF);
        rchk(`OFS_CD, 32'h0);
        rchk(8'hFC, 32'h0);
        // Full carry chain on a year end, periodic event on year field
        wr_reg(`OFS_CTRL, 32'h0);
        for (int i = 0; i < 8; i++) wr_reg({`BANK_TIME, 3'(i), 2'h0}, {20'h0, T_IN[i]});
        wr_reg(`OFS_PER_SEL, 32'h20);
        wr_reg(`OFS_STATUS, 32'h7);
        wr_reg(`OFS_CTRL, 32'h1);
        poll({`BANK_TIME, 3'h0, 2'h0}, 32'hFFF, 32'h0, n);
        chk({31'h0, n >= SEC_N - 3 && n <= SEC_N + 2}, 32'h1);
        for (int i = 1; i < 8; i++) rchk({`BANK_TIME, 3'(i), 2'h0}, {20'h0, T_OUT[i]});
        rd_reg(`OFS_STATUS, d);
        chk(d & 32'h2, 32'h2);
        // Date alarm on seconds only, with interrupt and wake
        wr_reg(`OFS_CTRL, 32'h0);
        wr_reg({`BANK_TIME, 3'h0, 2'h0}, 32'h0);
        wr_reg(8'h40, 32'h3);
        rchk(8'h40, 32'h3);
        wr_reg(`OFS_ALM_MASK, 32'hFE);
        wr_reg(`OFS_PER_SEL, 32'h0);
        wr_reg(`OFS_STATUS, 32'h7);
        wr_reg(`OFS_MASK, 32'h4);
        wr_reg(`OFS_WAKE, 32'h4);
        chk({30'h0, irq, wake}, 32'h0);
        wr_reg(`OFS_CTRL, 32'h1);
        poll(`OFS_STATUS, 32'h4, 32'h4, n);
        chk({31'h0, n >= 3 * SEC_N - 3 && n <= 3 * SEC_N + 3}, 32'h1);
        chk({30'h0, irq, wake}, 32'h3);
        rchk({`BANK_TIME, 3'h0, 2'h0}, 32'h3);
        wr_reg(`OFS_MASK, 32'h0);
        wr_reg(`OFS_WAKE, 32'h0);
        // Calibration: drop, then add, a second every second tick
        for (int dir = 1; dir >= 0; dir--) begin
            wr_reg(`OFS_CTRL, 32'h0);
            wr_reg({`BANK_TIME, 3'h0, 2'h0}, 32'h0);
            wr_reg(`OFS_CAL, {14'h0, 1'(dir), 17'h2});
            rchk(`OFS_CAL, {14'h0, 1'(dir), 17'h2});
            wr_reg(`OFS_CTRL, 32'h1);
            repeat (4 * SEC_N + 10) @(posedge clk);
            #1;
            rchk({`BANK_TIME, 3'h0, 2'h0}, (dir == 1) ? 32'h2 : 32'h6);
        end
        wr_reg(`OFS_CAL, 32'h0);
        // Countdown: full-range preset, then a short run to zero
        wr_reg(`OFS_STATUS, 32'h7);
        wr_reg(`OFS_CD, 32'hFFFF);
        rchk(`OFS_CD, 32'hFFFF_FFFF);
        wr_reg(`OFS_CD, 32'h5);
        rchk(`OFS_CD, 32'h0005_0005);
        rd_reg(`OFS_CD, d);
        rd_reg(`OFS_CD, d);
        poll(`OFS_STATUS, 32'h1, 32'h1, n);
        chk({31'h0, n >= 3 * MS_N && n <= 5 * MS_N + 1}, 32'h1);
        chk({31'h0, irq}, 32'h0);
        rchk(`OFS_CD, 32'h0005_0000);
        rchk(`OFS_CD, 32'h0005_0000);
        repeat (3 * MS_N) @(posedge clk);
        #1;
        rchk(`OFS_STATUS, 32'h1);
        wr_reg(`OFS_MASK, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr_reg(`OFS_WAKE, 32'h1);
        chk({31'h0, wake}, 32'h1);
        wr_reg(`OFS_STATUS, 32'h1);
        chk({30'h0, irq, wake}, 32'h0);
        wr_reg(`OFS_MASK, 32'h0);
        wr_reg(`OFS_WAKE, 32'h0);
        finish_test();
    end
endmodule

// Checker beside the top module, watching its ports only
bind rtc_calendar rtc_calendar_chk u_chk (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .wake(wake)
);
